// ===== hdl/pifb_pkg.sv
package pifb_pkg;
  // register byte addresses on the bus
  localparam logic [7:0] FLAGS_OFFSET     = 8'h0C;
  localparam logic [7:0] ENABLES_OFFSET   = 8'h8C;
  localparam logic [7:0] CORE_CTRL_OFFSET = 8'h10;

  // bit positions shared by the flag and enable registers
  localparam int unsigned PARPORT_BIT  = 7;
  localparam int unsigned ADC_BIT      = 6;
  localparam int unsigned RX_BIT       = 5;
  localparam int unsigned TX_BIT       = 4;
  localparam int unsigned SYNC_BIT     = 3;
  localparam int unsigned CAPCMP_BIT   = 2;
  localparam int unsigned TIMER_B_BIT  = 1;
  localparam int unsigned TIMER_A_BIT  = 0;

  // core control bits
  localparam int unsigned GLOBAL_EN_BIT = 7;
  localparam int unsigned GROUP_EN_BIT  = 6;

  // values after reset
  localparam logic [7:0] FLAGS_RESET   = 8'h00;
  localparam logic [7:0] ENABLES_RESET = 8'h00;
  localparam logic [7:0] CTRL_RESET    = 8'h00;

  // masks
  localparam logic [7:0] LEVEL_MASK   = 8'h30;
  localparam logic [7:0] FULL_IMPL    = 8'hFF;
  localparam logic [7:0] REDUCED_IMPL = 8'h4F;
  localparam logic [7:0] CTRL_MASK    = 8'hC0;

  // axi answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef logic [7:0] pifb_byte_t;
endpackage

// ===== hdl/pifb_bank_if.sv
`timescale 1ns/10ps
interface pifb_bank_if;
  import pifb_pkg::*;
  pifb_byte_t events;
  pifb_byte_t levels;
  pifb_byte_t wdata;
  logic       wr_flags;
  logic       wr_enables;
  pifb_byte_t flags;
  pifb_byte_t enables;

  modport ctrl (output events, levels, wdata, wr_flags, wr_enables,
                input  flags, enables);
  modport bank (input  events, levels, wdata, wr_flags, wr_enables,
                output flags, enables);
endinterface

// ===== hdl/pifb_bank.sv
`timescale 1ns/10ps
module pifb_bank #(
  parameter logic [7:0] IMPL = 8'hFF
) (
  // clock and reset
  input  wire logic   aclk,
  input  wire logic   aresetn,
  // register side
  pifb_bank_if.bank   bus
);
  import pifb_pkg::*;

  pifb_byte_t en_q;
  pifb_byte_t flag_q;
  wire [7:0]  en_d;
  wire [7:0]  flag_d;

  for (genvar i = 0; i < 8; i++) begin : g_bit
    assign en_d[i] = bus.wr_enables ? bus.wdata[i] : en_q[i];
    // event beats a software clear in the same cycle
    assign flag_d[i] = LEVEL_MASK[i] ? bus.levels[i] :
                       bus.events[i] ? 1'b1 :
                       bus.wr_flags  ? bus.wdata[i] : flag_q[i];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en_q <= ENABLES_RESET;
    end else begin
      en_q <= en_d & IMPL;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_q <= FLAGS_RESET;
    end else begin
      flag_q <= flag_d & IMPL;
    end
  end

  assign bus.flags   = flag_q;
  assign bus.enables = en_q;
endmodule

// ===== hdl/pifb_top.sv
// Notes on behaviour
// - every flag sets on its event, whatever the enables say.
// - enable register holds eight read/write enables, bit7 parport to bit0 timer A.
// - adc enable passes or blocks the conversion-done request.
// - serial receive enable passes or blocks the buffer-full request.
// - serial transmit enable passes or blocks the buffer-empty request.
// - sync serial and capture/compare enables pass or block their requests.
// - flags use enable bit order; rx and tx flags are read-only.
// - parport flag sets on any external access, held until software clears.
// - adc flag sets on conversion done, held until software clears.
// - rx flag mirrors a full receive buffer; writes do not clear it.
// - tx flag is high while transmit buffer is empty.
// - sync serial flag sets when a transfer finishes, software clears it.
// - capcmp flag sets on capture or compare, unused in pwm mode.
// - timer B match and timer A overflow flags held until cleared.
// - reduced variant has bits 7, 5, 4 unimplemented, reading zero.
// - all implemented bits reset to zero.
// - peripheral request on irq_req also needs the group enable; periph_pending does not.
// - global enable gates irq_req only; periph_pending is not gated; flags still set.
`timescale 1ns/10ps
module pifb_top
  import pifb_pkg::*;
#(
  parameter bit REDUCED_VARIANT = 1'b0
) (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // axi4-lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // peripheral events, one-cycle pulses, plus the capcmp pwm mode level
  input  wire logic        parport_access,
  input  wire logic        adc_done,
  input  wire logic        sync_serial_done,
  input  wire logic        capcmp_one_event,
  input  wire logic        capcmp_pwm_mode,
  input  wire logic        timer_b_match,
  input  wire logic        timer_a_ovf,
  // serial buffer levels
  input  wire logic        serial_rx_full,
  input  wire logic        serial_tx_empty,
  // toward the core
  output logic             periph_pending,
  output logic             irq_req
);
  import pifb_pkg::*;

  localparam logic [7:0] IMPL = REDUCED_VARIANT ? REDUCED_IMPL : FULL_IMPL;

  pifb_bank_if bank_bus ();

  // write channel state
  logic        awready_q;
  logic        wready_q;
  logic        aw_got_q;
  logic        w_got_q;
  logic [7:0]  waddr_q;
  pifb_byte_t  wbyte_q;
  logic        wlane_q;
  logic        bvalid_q;
  logic [1:0]  bresp_q;
  logic        aw_got_d;
  logic        w_got_d;
  logic        bvalid_d;
  logic        aw_hs;
  logic        w_hs;
  logic        b_hs;
  logic        do_wr;
  logic        wr_hit;

  // read channel state
  logic        arready_q;
  logic        rvalid_q;
  logic        rvalid_d;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  pifb_byte_t  rd_byte;
  logic        rd_hit;
  logic        ar_hs;
  logic        r_hs;

  // interrupt state
  pifb_byte_t  ctrl_q;
  logic        pending_q;
  logic        irq_req_q;
  logic        pending_d;

  assign aw_hs = s_axi_awvalid && awready_q;
  assign w_hs  = s_axi_wvalid && wready_q;
  assign b_hs  = bvalid_q && s_axi_bready;
  assign ar_hs = s_axi_arvalid && arready_q;
  assign r_hs  = rvalid_q && s_axi_rready;

  // address and data may come in either order; commit once both are held
  assign do_wr    = aw_got_q && w_got_q && !bvalid_q;
  assign aw_got_d = (aw_got_q || aw_hs) && !do_wr;
  assign w_got_d  = (w_got_q || w_hs) && !do_wr;
  assign bvalid_d = (bvalid_q || do_wr) && !b_hs;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q  <= 1'b0;
      w_got_q   <= 1'b0;
      bvalid_q  <= 1'b0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
    end else begin
      aw_got_q  <= aw_got_d;
      w_got_q   <= w_got_d;
      bvalid_q  <= bvalid_d;
      awready_q <= !aw_got_d && !bvalid_d;
      wready_q  <= !w_got_d && !bvalid_d;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      waddr_q <= 8'h00;
    end else if (aw_hs) begin
      waddr_q <= s_axi_awaddr;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wbyte_q <= 8'h00;
      wlane_q <= 1'b0;
    end else if (w_hs) begin
      wbyte_q <= s_axi_wdata[7:0];
      wlane_q <= s_axi_wstrb[0];
    end
  end

  always_comb begin
    if (waddr_q == FLAGS_OFFSET) begin
      wr_hit = 1'b1;
    end else if (waddr_q == ENABLES_OFFSET) begin
      wr_hit = 1'b1;
    end else if (waddr_q == CORE_CTRL_OFFSET) begin
      wr_hit = 1'b1;
    end else begin
      wr_hit = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bresp_q <= RESP_OKAY;
    end else if (do_wr) begin
      bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // a write whose low lane is off stores nothing but still answers okay
  assign bank_bus.wdata      = wbyte_q;
  assign bank_bus.wr_flags   = do_wr && wlane_q && (waddr_q == FLAGS_OFFSET);
  assign bank_bus.wr_enables = do_wr && wlane_q && (waddr_q == ENABLES_OFFSET);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= CTRL_RESET;
    end else if (do_wr && wlane_q && (waddr_q == CORE_CTRL_OFFSET)) begin
      ctrl_q <= wbyte_q & CTRL_MASK;
    end
  end

  // event sources; pwm mode leaves the capture/compare flag alone
  assign bank_bus.events = {parport_access,
                            adc_done,
                            2'b00,
                            sync_serial_done,
                            capcmp_one_event && !capcmp_pwm_mode,
                            timer_b_match,
                            timer_a_ovf};
  assign bank_bus.levels = {2'b00, serial_rx_full, serial_tx_empty, 4'h0};

  pifb_bank #(
    .IMPL (IMPL)
  ) u_bank (
    .aclk    (aclk),
    .aresetn (aresetn),
    .bus     (bank_bus)
  );

  // read path: one register stage, answer one cycle after the address
  always_comb begin
    if (s_axi_araddr == FLAGS_OFFSET) begin
      rd_byte = bank_bus.flags;
      rd_hit  = 1'b1;
    end else if (s_axi_araddr == ENABLES_OFFSET) begin
      rd_byte = bank_bus.enables;
      rd_hit  = 1'b1;
    end else if (s_axi_araddr == CORE_CTRL_OFFSET) begin
      rd_byte = ctrl_q;
      rd_hit  = 1'b1;
    end else begin
      rd_byte = 8'h00;
      rd_hit  = 1'b0;
    end
  end

  assign rvalid_d = (rvalid_q || ar_hs) && !r_hs;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q  <= 1'b0;
      arready_q <= 1'b0;
    end else begin
      rvalid_q  <= rvalid_d;
      arready_q <= !rvalid_d;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
    end else if (ar_hs) begin
      rdata_q <= {24'h00_0000, rd_byte};
      rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // request toward the core; registered, so one cycle behind the flags
  assign pending_d = |(bank_bus.flags & bank_bus.enables);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pending_q <= 1'b0;
      irq_req_q <= 1'b0;
    end else begin
      pending_q <= pending_d;
      irq_req_q <= pending_d && ctrl_q[GROUP_EN_BIT]
                   && ctrl_q[GLOBAL_EN_BIT];
    end
  end

  assign s_axi_awready  = awready_q;
  assign s_axi_wready   = wready_q;
  assign s_axi_bvalid   = bvalid_q;
  assign s_axi_bresp    = bresp_q;
  assign s_axi_arready  = arready_q;
  assign s_axi_rvalid   = rvalid_q;
  assign s_axi_rdata    = rdata_q;
  assign s_axi_rresp    = rresp_q;
  assign periph_pending = pending_q;
  assign irq_req        = irq_req_q;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  pifb_byte_t edge_ev;
  assign edge_ev = bank_bus.events & IMPL & ~LEVEL_MASK;

  chk_flag_event_set: assert property (
    (edge_ev != 8'h00) |=> ((bank_bus.flags & $past(edge_ev)) == $past(edge_ev)))
    else $error("flag missed its event");

  chk_flag_hold_edge: assert property (
    (edge_ev == 8'h00 && !bank_bus.wr_flags) |=>
      ((bank_bus.flags & ~LEVEL_MASK) == ($past(bank_bus.flags) & ~LEVEL_MASK)))
    else $error("flag changed without event or write");

  chk_flag_write_sw: assert property (
    (bank_bus.wr_flags && edge_ev == 8'h00) |=>
      ((bank_bus.flags & ~LEVEL_MASK) == ($past(bank_bus.wdata) & IMPL & ~LEVEL_MASK)))
    else $error("flag write not stored");

  chk_rx_flag_mirror: assert property (
    IMPL[RX_BIT] |=> (bank_bus.flags[RX_BIT] == $past(serial_rx_full)))
    else $error("rx flag does not follow buffer");

  chk_tx_flag_mirror: assert property (
    IMPL[TX_BIT] |=> (bank_bus.flags[TX_BIT] == $past(serial_tx_empty)))
    else $error("tx flag does not follow buffer");

  chk_enable_write_store: assert property (
    bank_bus.wr_enables |=> (bank_bus.enables == ($past(bank_bus.wdata) & IMPL)))
    else $error("enable write not stored");

  chk_unimpl_zero: assert property (
    ((bank_bus.flags | bank_bus.enables) & ~IMPL) == 8'h00)
    else $error("unimplemented bit set");

  chk_masked_quiet: assert property (
    ((bank_bus.flags & bank_bus.enables) == 8'h00) |=> !pending_q)
    else $error("pending without enabled flag");

  chk_irq_gate_path: assert property (
    irq_req_q == ($past(pending_d) && $past(ctrl_q[GROUP_EN_BIT])
                  && $past(ctrl_q[GLOBAL_EN_BIT])))
    else $error("irq request gating wrong");

  chk_write_answer: assert property (
    (aw_hs && w_hs) |=> ##1 bvalid_q)
    else $error("write answer late");

  chk_read_answer: assert property (
    ar_hs |=> (rvalid_q && rdata_q[31:8] == 24'h00_0000))
    else $error("read answer late or dirty");

  cov_irq_raised: cover property (!irq_req_q ##1 irq_req_q);
  cov_set_over_clear: cover property (bank_bus.wr_flags && edge_ev != 8'h00);
  cov_write_then_read: cover property (b_hs ##[1:10] r_hs);
endmodule

// ===== tb/pifb_periph_model.sv
`timescale 1ns/10ps
module pifb_periph_model
  import pifb_pkg::*;
(
  // clock
  input  wire logic       aclk,
  // bench commands
  input  wire pifb_byte_t fire,
  input  wire logic       rx_level,
  input  wire logic       tx_level,
  // peripheral strobes
  output logic            parport_access   = 1'b0,
  output logic            adc_done         = 1'b0,
  output logic            sync_serial_done = 1'b0,
  output logic            capcmp_one_event = 1'b0,
  output logic            timer_b_match    = 1'b0,
  output logic            timer_a_ovf      = 1'b0,
  // serial buffer levels
  output logic            serial_rx_full   = 1'b0,
  output logic            serial_tx_empty  = 1'b0
);
  // one registered pulse per fire bit except bits 5 and 4, like a peripheral's own event flop
  always @(posedge aclk) begin
    parport_access   <= fire[PARPORT_BIT];
    adc_done         <= fire[ADC_BIT];
    sync_serial_done <= fire[SYNC_BIT];
    capcmp_one_event <= fire[CAPCMP_BIT];
    timer_b_match    <= fire[TIMER_B_BIT];
    timer_a_ovf      <= fire[TIMER_A_BIT];
    serial_rx_full   <= rx_level;
    serial_tx_empty  <= tx_level;
  end
endmodule

// ===== tb/test_peripheral_irq_enable_flag_bank.sv
`timescale 1ns/10ps
module test_peripheral_irq_enable_flag_bank;
  import pifb_pkg::*;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        parport_access, adc_done, sync_serial_done, capcmp_one_event;
  logic        timer_b_match, timer_a_ovf, serial_rx_full, serial_tx_empty;
  logic        capcmp_pwm_mode = 1'b0, periph_pending, irq_req;
  logic        rx_lvl = 1'b0, tx_lvl = 1'b0;
  pifb_byte_t  fire = 8'h00;
  int          fails = 0, compares = 0;
  int          pb[6] = '{7, 6, 3, 2, 1, 0};

  pifb_top u_pifb_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .parport_access,
    .adc_done, .sync_serial_done, .capcmp_one_event, .capcmp_pwm_mode, .timer_b_match,
    .timer_a_ovf, .serial_rx_full, .serial_tx_empty, .periph_pending, .irq_req);

  pifb_periph_model u_pifb_periph_model (.aclk, .fire, .rx_level(rx_lvl),
    .tx_level(tx_lvl), .parport_access, .adc_done, .sync_serial_done,
    .capcmp_one_event, .timer_b_match, .timer_a_ovf, .serial_rx_full, .serial_tx_empty);

  initial begin
    forever #12.5 aclk = ~aclk;
  end

  task give_verdict;
    if (fails == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // bready stays high, so a finished write never toggles it
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
    bit aw, w, b;
    aw = 1;
    w = 1;
    b = 1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (b) begin
      @(posedge aclk);
      if (aw && s_axi_awready) begin
        aw = 0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready) begin
        w = 0;
        s_axi_wvalid <= 1'b0;
      end
      if (!aw && !w && s_axi_bvalid) begin
        b = 0;
        chk({30'h0, s_axi_bresp}, {30'h0, er});
      end
    end
  endtask

  task rdc(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er = RESP_OKAY);
    bit ar, r;
    ar = 1;
    r = 1;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    while (r) begin
      @(posedge aclk);
      if (ar && s_axi_arready) begin
        ar = 0;
        s_axi_arvalid <= 1'b0;
      end
      else if (!ar && s_axi_rvalid) begin
        r = 0;
        chk(s_axi_rdata, exp);
        chk({30'h0, s_axi_rresp}, {30'h0, er});
      end
    end
  endtask

  task pulse(input pifb_byte_t m);
    fire <= m;
    @(posedge aclk);
    fire <= 8'h00;
    repeat (2) @(posedge aclk);
  endtask

  // a level input needs three edges: model, flag, then the registered request
  task settle;
    repeat (4) @(posedge aclk);
  endtask

  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rdc(FLAGS_OFFSET, 32'h0);
    rdc(ENABLES_OFFSET, 32'h0);
    rdc(CORE_CTRL_OFFSET, 32'h0);
    wr(ENABLES_OFFSET, 32'hFFFF_FFA5);
    rdc(ENABLES_OFFSET, 32'hA5);
    wr(ENABLES_OFFSET, 32'h5A);
    rdc(ENABLES_OFFSET, 32'h5A);
    wr(CORE_CTRL_OFFSET, 32'hFF);
    rdc(CORE_CTRL_OFFSET, 32'hC0);
    wr(CORE_CTRL_OFFSET, 32'h00);
    wr(ENABLES_OFFSET, 32'h00);
    // low byte lane off: nothing stored, still an okay answer
    s_axi_wstrb <= 4'hE;
    wr(ENABLES_OFFSET, 32'hFF);
    s_axi_wstrb <= 4'hF;
    rdc(ENABLES_OFFSET, 32'h0);
    rdc(8'h44, 32'h0, RESP_SLVERR);
    wr(8'h44, 32'hFF, RESP_SLVERR);
    // events land with every enable off and the core gate shut
    foreach (pb[i]) begin
      pulse(8'h01 << pb[i]);
      settle();
      rdc(FLAGS_OFFSET, 32'h1 << pb[i]);
      chk({31'h0, irq_req}, 32'h0);
      wr(FLAGS_OFFSET, 32'h0);
      rdc(FLAGS_OFFSET, 32'h0);
    end
    capcmp_pwm_mode <= 1'b1;
    pulse(8'h04);
    capcmp_pwm_mode <= 1'b0;
    rdc(FLAGS_OFFSET, 32'h0);
    pulse(8'h04);
    rdc(FLAGS_OFFSET, 32'h04);
    wr(FLAGS_OFFSET, 32'h0);
    rx_lvl <= 1'b1;
    tx_lvl <= 1'b1;
    settle();
    wr(FLAGS_OFFSET, 32'h0);
    rdc(FLAGS_OFFSET, 32'h30);
    rx_lvl <= 1'b0;
    settle();
    rdc(FLAGS_OFFSET, 32'h10);
    tx_lvl <= 1'b0;
    settle();
    rdc(FLAGS_OFFSET, 32'h00);
    // one source at a time through every gate
    wr(CORE_CTRL_OFFSET, 32'hC0);
    for (int b = 0; b < 8; b++) begin
      wr(FLAGS_OFFSET, 32'h0);
      wr(ENABLES_OFFSET, 32'h1 << b);
      if (b == RX_BIT) rx_lvl <= 1'b1;
      else if (b == TX_BIT) tx_lvl <= 1'b1;
      else pulse(8'h01 << b);
      settle();
      chk({31'h0, irq_req}, 32'h1);
      wr(CORE_CTRL_OFFSET, 32'h40);
      settle();
      chk({31'h0, irq_req}, 32'h0);
      chk({31'h0, periph_pending}, 32'h1);
      wr(CORE_CTRL_OFFSET, 32'h80);
      settle();
      chk({31'h0, irq_req}, 32'h0);
      wr(CORE_CTRL_OFFSET, 32'hC0);
      wr(ENABLES_OFFSET, ~(32'h1 << b) & 32'hFF);
      settle();
      chk({31'h0, irq_req}, 32'h0);
      chk({31'h0, periph_pending}, 32'h0);
      rx_lvl <= 1'b0;
      tx_lvl <= 1'b0;
    end
    give_verdict();
  end

  initial begin
    repeat (20000) @(posedge aclk);
    fails++;
    give_verdict();
  end
endmodule
